// [hw/alarm_pkg.sv]
/*
  Constants and types shared by the sensor alarm monitor and its helpers.
  Assumes 16-bit sensor words, seven source streams and byte register offsets.
*/
package alarm_pkg;

  localparam int DATA_W = 16;
  localparam int NUM_SRC = 7;
  localparam int NUM_ALARMS = 2;
  localparam int STREAM_BUS_W = NUM_SRC * DATA_W;
  localparam int HIST_AW = 8;
  localparam int HIST_DEPTH = 256;
  localparam int DIFF_W = DATA_W + 1;
  localparam int THR_W = 14;

  localparam logic [7:0] ADDR_THR1 = 8'h26;
  localparam logic [7:0] ADDR_THR2 = 8'h28;
  localparam logic [7:0] ADDR_PER1 = 8'h2a;
  localparam logic [7:0] ADDR_PER2 = 8'h2c;
  localparam logic [7:0] ADDR_CFG = 8'h2e;
  localparam logic [7:0] ADDR_DIAG = 8'h3c;

  localparam int THR_DIR_BIT = 15;
  localparam int THR_MSB = 13;
  localparam int PER_MSB = 7;
  localparam int CFG_SRC1_LSB = 8;
  localparam int CFG_SRC_W = 4;
  localparam int CFG_MODE1_BIT = 6;
  localparam int CFG_FILT_BIT = 4;
  localparam int CFG_IND_EN_BIT = 2;
  localparam int CFG_IND_POL_BIT = 1;
  localparam int CFG_IND_LINE_BIT = 0;
  localparam int DIAG_ALM1_BIT = 8;

  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] PER_ONE = 8'h01;

  typedef enum logic [3:0] {
    SRC_DISABLED = 4'b0000,
    SRC_GYRO_X = 4'b0001,
    SRC_GYRO_Y = 4'b0010,
    SRC_GYRO_Z = 4'b0011,
    SRC_ACCEL_X = 4'b0100,
    SRC_ACCEL_Y = 4'b0101,
    SRC_ACCEL_Z = 4'b0110,
    SRC_TEMP = 4'b0111
  } source_sel_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_JUDGE = 2'b01
  } eval_state_type;

endpackage

// [hw/alarm_history_mem.sv]
/*
  Sample history store for one alarm: one write and one read port.
  Read data come out of a register one enabled clock after the read request.
*/
`timescale 1ns/1ps
module alarm_history_mem (
  input wire logic sys_clk_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [alarm_pkg::HIST_AW-1:0] wr_addr_i,
  input wire logic [alarm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [alarm_pkg::HIST_AW-1:0] rd_addr_i,
  output logic [alarm_pkg::DATA_W-1:0] rd_data_o
);
  import alarm_pkg::*;

  logic [DATA_W-1:0] mem [HIST_DEPTH];

  // No reset on the array so it maps to block memory
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// [hw/alarm_compare.sv]
/*
  Signed threshold comparator for one alarm.
  Assumes the value and the 14-bit threshold share the source's two's complement scale.
*/
`timescale 1ns/1ps
module alarm_compare (
  input wire logic signed [alarm_pkg::DIFF_W-1:0] value_i,
  input wire logic [alarm_pkg::THR_W-1:0] threshold_i,
  input wire logic above_i,
  output logic hit_o
);
  import alarm_pkg::*;

  logic signed [DIFF_W-1:0] thr_ext;

  always_comb begin
    thr_ext = {{(DIFF_W - THR_W){threshold_i[THR_W-1]}}, threshold_i};
    if (above_i) begin
      hit_o = value_i > thr_ext;
    end else begin
      hit_o = value_i < thr_ext;
    end
  end

endmodule

// [hw/sensor_alarm_monitor.sv]
/*
  Two programmable alarm monitors on the sensor output streams, with their
  configuration registers, diagnostic alarm flags and indicator pin drive.
  Assumes sample_strobe_i pulses once per sample cycle on sys_clk_i, after the
  new raw and filtered words are stable on the stream buses.
*/
`timescale 1ns/1ps
module sensor_alarm_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sample_strobe_i,
  input wire logic [alarm_pkg::STREAM_BUS_W-1:0] raw_data_i,
  input wire logic [alarm_pkg::STREAM_BUS_W-1:0] filt_data_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [alarm_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [alarm_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic gp_line_one_o,
  output logic gp_line_one_oe_o,
  output logic gp_line_two_o,
  output logic gp_line_two_oe_o
);
  import alarm_pkg::*;

  logic [DATA_W-1:0] alarm_config;
  logic [NUM_ALARMS-1:0][DATA_W-1:0] alarm_threshold;
  logic [NUM_ALARMS-1:0][DATA_W-1:0] alarm_sample_period;
  logic [NUM_ALARMS-1:0] diagnostic_flags;
  logic [NUM_ALARMS-1:0] alarm_active;
  logic [NUM_ALARMS-1:0] alarm_hit;
  eval_state_type eval_state;
  eval_state_type next_eval_state;
  logic [HIST_AW-1:0] wr_ptr;
  logic capture;
  logic judge;
  logic diag_read;
  logic cfg_write;
  logic use_filtered;
  logic next_ind_level;
  logic [DATA_W-1:0] next_rdata;
  logic next_line_one_oe;
  logic next_line_two_oe;

  function automatic logic [DATA_W-1:0] pick_stream(
    input logic [STREAM_BUS_W-1:0] bus,
    input logic [CFG_SRC_W-1:0] src
  );
    logic [DATA_W-1:0] r;
    r = '0;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (src == CFG_SRC_W'(k + 1)) begin
        r = bus[k*DATA_W +: DATA_W];
      end
    end
    return r;
  endfunction

  assign capture = ce_i && (eval_state == ST_IDLE) && sample_strobe_i;
  assign judge = ce_i && (eval_state == ST_JUDGE);
  assign diag_read = ce_i && reg_rd_i && (reg_addr_i == ADDR_DIAG);
  assign cfg_write = ce_i && reg_wr_i && (reg_addr_i == ADDR_CFG);
  assign use_filtered = alarm_config[CFG_FILT_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      alarm_config <= REG_RESET;
    end else if (cfg_write) begin
      alarm_config <= reg_wdata_i;
    end
  end

  // Strobes arriving during the judge cycle are dropped; samples are far apart
  always_comb begin
    next_eval_state = eval_state;
    case (eval_state)
      ST_IDLE: begin
        if (sample_strobe_i) begin
          next_eval_state = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        next_eval_state = ST_IDLE;
      end
      default: begin
        next_eval_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      eval_state <= ST_IDLE;
    end else if (ce_i) begin
      eval_state <= next_eval_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
    end else if (capture) begin
      wr_ptr <= wr_ptr + HIST_AW'(1);
    end
  end

  for (genvar i = 0; i < NUM_ALARMS; i++) begin : g_alarm
    logic [CFG_SRC_W-1:0] src;
    logic enabled;
    logic dynamic;
    logic [7:0] span;
    logic [7:0] fill_cnt;
    logic fill_ok;
    logic [DATA_W-1:0] sel_sample;
    logic [DATA_W-1:0] cur;
    logic [DATA_W-1:0] past;
    logic [HIST_AW-1:0] rd_addr;
    logic signed [DIFF_W-1:0] value;
    logic raw_hit;
    logic hit;
    logic thr_write;
    logic per_write;

    assign src = alarm_config[CFG_SRC1_LSB + CFG_SRC_W*i +: CFG_SRC_W];
    assign dynamic = alarm_config[CFG_MODE1_BIT + i];
    assign rd_addr = wr_ptr - span;
    assign thr_write = ce_i && reg_wr_i && (reg_addr_i == ADDR_THR1 + 8'(2*i));
    assign per_write = ce_i && reg_wr_i && (reg_addr_i == ADDR_PER1 + 8'(2*i));

    // Codes 8 to 15 are reserved and treated like the disable code
    always_comb begin
      case (src)
        SRC_GYRO_X, SRC_GYRO_Y, SRC_GYRO_Z, SRC_ACCEL_X, SRC_ACCEL_Y, SRC_ACCEL_Z, SRC_TEMP: begin
          enabled = 1'b1;
        end
        default: begin
          enabled = 1'b0;
        end
      endcase
    end

    always_comb begin
      if (use_filtered) begin
        sel_sample = pick_stream(filt_data_i, src);
      end else begin
        sel_sample = pick_stream(raw_data_i, src);
      end
    end

    // Both zero and one mean a single sample back
    always_comb begin
      if (alarm_sample_period[i][PER_MSB:0] == 8'h00) begin
        span = PER_ONE;
      end else begin
        span = alarm_sample_period[i][PER_MSB:0];
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        alarm_threshold[i] <= REG_RESET;
      end else if (thr_write) begin
        alarm_threshold[i] <= reg_wdata_i;
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        alarm_sample_period[i] <= REG_RESET;
      end else if (per_write) begin
        alarm_sample_period[i] <= reg_wdata_i;
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        cur <= '0;
      end else if (capture && enabled) begin
        cur <= sel_sample;
      end
    end

    // Fill count keeps dynamic checks quiet until the history holds enough samples
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        fill_cnt <= '0;
        fill_ok <= 1'b0;
      end else if (ce_i) begin
        if (!enabled) begin
          fill_cnt <= '0;
          fill_ok <= 1'b0;
        end else if (capture) begin
          fill_ok <= fill_cnt >= span;
          if (fill_cnt != 8'hff) begin
            fill_cnt <= fill_cnt + 8'h01;
          end
        end
      end
    end

    alarm_history_mem u_hist (
      .sys_clk_i(sys_clk_i),
      .ce_i(ce_i),
      .wr_en_i(capture),
      .wr_addr_i(wr_ptr),
      .wr_data_i(sel_sample),
      .rd_en_i(capture),
      .rd_addr_i(rd_addr),
      .rd_data_o(past)
    );

    always_comb begin
      if (dynamic) begin
        value = $signed({cur[DATA_W-1], cur}) - $signed({past[DATA_W-1], past});
      end else begin
        value = $signed({cur[DATA_W-1], cur});
      end
    end

    alarm_compare u_cmp (
      .value_i(value),
      .threshold_i(alarm_threshold[i][THR_MSB:0]),
      .above_i(alarm_threshold[i][THR_DIR_BIT]),
      .hit_o(raw_hit)
    );

    // Static checks ignore the fill count; disabled alarms never hit
    always_comb begin
      if (!enabled) begin
        hit = 1'b0;
      end else if (dynamic) begin
        hit = raw_hit && fill_ok;
      end else begin
        hit = raw_hit;
      end
    end

    assign alarm_hit[i] = hit;

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        alarm_active[i] <= 1'b0;
      end else if (judge) begin
        alarm_active[i] <= alarm_hit[i];
      end
    end

    // A new hit wins over a clearing read in the same cycle
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        diagnostic_flags[i] <= 1'b0;
      end else if (judge && alarm_hit[i]) begin
        diagnostic_flags[i] <= 1'b1;
      end else if (diag_read) begin
        diagnostic_flags[i] <= 1'b0;
      end
    end
  end

  // Unmapped addresses read as zero rather than aliasing a register
  always_comb begin
    case (reg_addr_i)
      ADDR_THR1: begin
        next_rdata = alarm_threshold[0];
      end
      ADDR_THR2: begin
        next_rdata = alarm_threshold[1];
      end
      ADDR_PER1: begin
        next_rdata = alarm_sample_period[0];
      end
      ADDR_PER2: begin
        next_rdata = alarm_sample_period[1];
      end
      ADDR_CFG: begin
        next_rdata = alarm_config;
      end
      ADDR_DIAG: begin
        next_rdata = DATA_W'({diagnostic_flags, 8'h00});
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  assign next_ind_level = (|alarm_active) ? alarm_config[CFG_IND_POL_BIT] : !alarm_config[CFG_IND_POL_BIT];
  assign next_line_one_oe = alarm_config[CFG_IND_EN_BIT] && !alarm_config[CFG_IND_LINE_BIT];
  assign next_line_two_oe = alarm_config[CFG_IND_EN_BIT] && alarm_config[CFG_IND_LINE_BIT];

  // Line not selected is released so other functions may own it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gp_line_one_o <= 1'b0;
      gp_line_one_oe_o <= 1'b0;
    end else if (ce_i) begin
      gp_line_one_oe_o <= next_line_one_oe;
      gp_line_one_o <= next_line_one_oe && next_ind_level;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gp_line_two_o <= 1'b0;
      gp_line_two_oe_o <= 1'b0;
    end else if (ce_i) begin
      gp_line_two_oe_o <= next_line_two_oe;
      gp_line_two_o <= next_line_two_oe && next_ind_level;
    end
  end

endmodule

// [tb/sensor_alarm_monitor_asserts.sv]
/*
  Port-level checker for the alarm monitor.
  Assumes it is bound to sensor_alarm_monitor; sees its ports only.
*/
`timescale 1ns/1ps
module sensor_alarm_monitor_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sample_strobe_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [alarm_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic gp_line_one_o,
  input wire logic gp_line_one_oe_o,
  input wire logic gp_line_two_o,
  input wire logic gp_line_two_oe_o
);
  import alarm_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // No strobe here, so no judge can land on the following read edge
  sequence diag_rd;
    ce_i && reg_rd_i && reg_addr_i == ADDR_DIAG && !sample_strobe_i;
  endsequence
  sequence odd_rd;
    ce_i && reg_rd_i && !(reg_addr_i inside {8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e, 8'h3c});
  endsequence
  AST_RD_ANSWER: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  AST_RD_HOLD: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (odd_rd |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_DIAG_ZERO: assert property (diag_rd |=> reg_rdata_o[15:10] == 6'h00 && reg_rdata_o[7:0] == 8'h00)
    else $error("diagnostic word has stray bits");
  AST_DIAG_CLEAR: assert property ((ce_i && !sample_strobe_i) ##1 diag_rd ##1 diag_rd |=> reg_rdata_o[9:8] == 2'b00)
    else $error("flags not cleared by read");
  AST_LINES_EXCL: assert property (!(gp_line_one_oe_o && gp_line_two_oe_o))
    else $error("both indicator lines driven");
  AST_ONE_OFF: assert property (!gp_line_one_oe_o |-> !gp_line_one_o)
    else $error("line one level while undriven");
  AST_TWO_OFF: assert property (!gp_line_two_oe_o |-> !gp_line_two_o)
    else $error("line two level while undriven");
endmodule
bind sensor_alarm_monitor sensor_alarm_monitor_asserts i_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .sample_strobe_i(sample_strobe_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .gp_line_one_o(gp_line_one_o), .gp_line_one_oe_o(gp_line_one_oe_o),
  .gp_line_two_o(gp_line_two_o), .gp_line_two_oe_o(gp_line_two_oe_o));

// [tb/sensor_alarm_monitor_tb.sv]
/*
  Self-checking bench for sensor_alarm_monitor: static and dynamic alarms,
  flag clearing, indicator pins, register reset and access.
  Assumes the checker file is compiled with it; one 40 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module sensor_alarm_monitor_tb;
  import alarm_pkg::*;
  typedef struct {logic [15:0] cfg, thr, rv, fv; int k; logic [1:0] fl;} case_type;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic strobe = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [STREAM_BUS_W-1:0] raw = '0;
  logic [STREAM_BUS_W-1:0] filt = '0;
  logic [15:0] rdata, got;
  logic rvalid, o1, oe1, o2, oe2;
  int fail_count = 0;
  int checks_done = 0;
  // Unselected slices stay zero, so a wrong source choice misses the hit in all rows but the third, where zero is also below 0x0064
  case_type rows[10] = '{
    '{16'h0106, 16'h8064, 16'h0065, 16'h0000, 0, 2'b01},
    '{16'h0106, 16'h8064, 16'h0064, 16'h0000, 0, 2'b00},
    '{16'h0705, 16'h0064, 16'h0063, 16'h0000, 6, 2'b01},
    '{16'h0100, 16'hc064, 16'h0065, 16'h0000, 0, 2'b01},
    '{16'h0200, 16'h3fff, 16'hfffe, 16'h0000, 1, 2'b01},
    '{16'h0616, 16'h8064, 16'h0000, 16'h00c8, 5, 2'b01},
    '{16'h0616, 16'h8064, 16'h00c8, 16'h0000, 5, 2'b00},
    '{16'h3007, 16'h8064, 16'h0065, 16'h0000, 2, 2'b10},
    '{16'h0006, 16'h8064, 16'h0065, 16'h0000, 0, 2'b00},
    '{16'h0105, 16'h8064, 16'h0064, 16'h0000, 0, 2'b00}};

  always #12.5 sys_clk = ~sys_clk;

  sensor_alarm_monitor i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .sample_strobe_i(strobe),
    .raw_data_i(raw), .filt_data_i(filt), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .gp_line_one_o(o1),
    .gp_line_one_oe_o(oe1), .gp_line_two_o(o2), .gp_line_two_oe_o(oe2));

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    rd = 1'b1;
    addr = a;
    @(negedge sys_clk);
    rd = 1'b0;
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask

  // Strobe, then wait past the judge edge and the pin update edge
  task automatic samp(input int k, input logic [15:0] rv, input logic [15:0] fv);
    @(negedge sys_clk);
    raw = '0;
    filt = '0;
    raw[k*16+:16] = rv;
    filt[k*16+:16] = fv;
    strobe = 1'b1;
    @(negedge sys_clk);
    strobe = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic diag(input logic [1:0] fl);
    rreg(ADDR_DIAG, got);
    `CHK(got[9:8], fl)
  endtask

  task automatic pins(input logic [15:0] c, input logic act);
    logic lvl;
    lvl = act ? c[1] : !c[1];
    `CHK({oe2, o2, oe1, o1}, {c[2] & c[0], c[2] & c[0] & lvl, c[2] & !c[0], c[2] & !c[0] & lvl})
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      wreg(ADDR_CFG, rows[i].cfg);
      wreg(ADDR_THR1, rows[i].thr);
      wreg(ADDR_THR2, rows[i].thr);
      samp(rows[i].k, rows[i].rv, rows[i].fv);
      pins(rows[i].cfg, rows[i].fl != 2'b00);
      diag(rows[i].fl);
    end
    wreg(ADDR_THR1, 16'h8064);
    wreg(ADDR_THR2, 16'h8064);
    for (int c = 1; c < 8; c++) begin
      wreg(ADDR_CFG, {c[3:0], c[3:0], 8'h00});
      samp(c - 1, 16'h0065, 16'h0000);
      diag(2'b11);
    end
    diag(2'b00);
    samp(6, 16'h0065, 16'h0000);
    diag(2'b11);
    // Two reads in a row: the second sees the flags already cleared
    samp(6, 16'h0065, 16'h0000);
    @(negedge sys_clk);
    rd = 1'b1;
    addr = ADDR_DIAG;
    @(negedge sys_clk);
    `CHK(rdata[9:8], 2'b11)
    @(negedge sys_clk);
    rd = 1'b0;
    `CHK(rdata[9:8], 2'b00)
    // Period 3 with unused upper bits set; early history is not judged
    wreg(ADDR_CFG, 16'h0000);
    wreg(ADDR_PER1, 16'hff03);
    wreg(ADDR_CFG, 16'h0140);
    repeat (3) samp(0, 16'h0000, 16'h0000);
    rreg(ADDR_DIAG, got);
    samp(0, 16'h0064, 16'h0000);
    diag(2'b00);
    samp(0, 16'h0065, 16'h0000);
    diag(2'b01);
    wreg(ADDR_CFG, 16'h0000);
    wreg(ADDR_PER1, 16'h0000);
    wreg(ADDR_CFG, 16'h0140);
    samp(0, 16'h0000, 16'h0000);
    rreg(ADDR_DIAG, got);
    samp(0, 16'h0065, 16'h0000);
    diag(2'b01);
    // Alarm 2 in dynamic mode, indicator on line one while it is active
    wreg(ADDR_CFG, 16'h0000);
    wreg(ADDR_PER2, 16'h0001);
    wreg(ADDR_CFG, 16'h1086);
    samp(0, 16'h0000, 16'h0000);
    rreg(ADDR_DIAG, got);
    samp(0, 16'h0065, 16'h0000);
    pins(16'h1086, 1'b1);
    diag(2'b10);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    `CHK({oe2, o2, oe1, o1, rvalid}, 5'h00)
    for (int i = 0; i < 5; i++) begin
      rreg(8'h26 + 8'(2 * i), got);
      `CHK(got, REG_RESET)
    end
    wreg(ADDR_THR1, 16'hc064);
    rreg(ADDR_THR1, got);
    `CHK(got, 16'hc064)
    rreg(8'h30, got);
    `CHK(got, 16'h0000)
    ce = 1'b0;
    wreg(ADDR_CFG, 16'h0106);
    ce = 1'b1;
    rreg(ADDR_CFG, got);
    `CHK(got, 16'h0000)
    conclude();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
endmodule
